// ### tac_consts.svh
// Constants for the tag anticollision command decoder
`ifndef TAC_CONSTS_SVH
`define TAC_CONSTS_SVH
`define TAC_CODE_SLOT 4'h6
`define TAC_CODE_SEARCH_LO 8'h00
`define TAC_CODE_ROUND_LO 8'h04
`define TAC_CODE_READ 8'h08
`define TAC_CODE_WRITE 8'h09
`define TAC_CODE_FETCH 8'h0B
`define TAC_CODE_SORT 8'h0C
`define TAC_CODE_PICK 8'h0E
`define TAC_CODE_RETIRE 8'h0F
`define TAC_LFSR_SEED 16'hACE1
`define TAC_LFSR_TAPS 16'hB400
`define TAC_MAX_LEN 3'h5
`define TAC_LEN_SHORT 3'h3
`define TAC_LEN_LONG 3'h4
`endif

// ### tac_pkg.sv
// Types for the tag anticollision command decoder
`default_nettype none
package tac_pkg;
	typedef enum logic [1:0] {TAC_READY, TAC_INVENTORY, TAC_SELECTED} tac_state_e;
	typedef logic [7:0] tac_byte_t;
endpackage : tac_pkg
`default_nettype wire

// ### tac_rand.sv
// Free-running pseudo-random source
`timescale 1ns/1ps
`default_nettype none
`include "tac_consts.svh"
module tac_rand (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Random value
	output logic [7:0] rand_o
);
	logic [15:0] lfsr_ff;
	wire fb = lfsr_ff[0];
	wire [15:0] nxt_lfsr = fb ? ((lfsr_ff >> 1) ^ `TAC_LFSR_TAPS) : (lfsr_ff >> 1);
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			lfsr_ff <= `TAC_LFSR_SEED;
		end else begin
			lfsr_ff <= nxt_lfsr;
		end
	end
	assign rand_o = lfsr_ff[7:0];
endmodule : tac_rand
`default_nettype wire

// ### tac_decoder.sv
// Anticollision command decoder of the contactless tag
// Summary of operation
// R01: Commands decode by first byte; low nibble 6 means a slot request.
// R02: Search-begin is 06h,00h then low and high check bytes.
// R03: Search-begin moves Ready to Inventory, draws new identifier, replies.
// R04: Search-begin reply ignores the slot draw.
// R05: Reader uses search-begin mainly when one Ready tag is expected.
// R06: Slot-round-open is 06h,04h then low and high check bytes.
// R07: Slot-round-open and slot-probe act only in Inventory state.
// R08: Slot-round-open draws slot 0..15 into identifier low nibble.
// R09: Slot draw held until next round-open or search-begin or power loss.
// R10: After drawing, slot zero replies with identifier, else silent.
// R11: Probe byte: low nibble 6, high nibble slot index 1..15.
// R12: Slot-probe is one code byte then the two check bytes.
// R13: Probe replies identifier only when held slot equals index.
// R14: Reader opens a round then probes remaining slots, picking singles.
// R15: Reader repeats rounds after collisions, ignoring already picked identifiers.
// R16: Tag-pick 0Eh with matching identifier selects and echoes identifier.
// R17: Return-to-sorting 0Ch sends Selected to Inventory silently.
// R18: Bad check or wrong length request is discarded without effect.
// R19: Identifier and slot values come from a free-running random source.
`timescale 1ns/1ps
`default_nettype none
`include "tac_consts.svh"
module tac_decoder
	import tac_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Request frame from the framer, same clock
	input wire logic req_byte_valid_i,
	input wire logic [7:0] req_byte_i,
	input wire logic req_end_i,
	input wire logic req_check_ok_i,
	// Reply
	output logic reply_valid_o,
	output logic [7:0] reply_byte_o,
	// State
	output logic [1:0] tag_state_o
);
	////////////////////////////////////////////////////////////////
	// Request capture; the two check bytes are counted in the length
	tac_state_e state_ff;
	logic [7:0] session_identifier_ff;
	logic [7:0] byte0_ff;
	logic [7:0] byte1_ff;
	logic [2:0] len_ff;
	logic reply_valid_ff;
	logic [7:0] reply_byte_ff;
	logic [7:0] rand_val;

	tac_rand u_rand (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.rand_o(rand_val) // R19
	);

	// Saturates one past the longest frame, so an overlong frame never looks exact
	wire [2:0] nxt_len = (len_ff == `TAC_MAX_LEN) ? len_ff : len_ff + 3'h1; // R18
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			len_ff <= 3'h0;
			byte0_ff <= 8'h00;
			byte1_ff <= 8'h00;
		end else if (req_end_i) begin
			len_ff <= 3'h0;
		end else if (req_byte_valid_i) begin
			len_ff <= nxt_len;
			if (len_ff == 3'h0) begin
				byte0_ff <= req_byte_i;
			end
			if (len_ff == 3'h1) begin
				byte1_ff <= req_byte_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Decoding
	// Two-byte anticollision code with the exact long frame length
	function automatic logic code_pair(input logic [7:0] first, input logic [7:0] second,
		input logic [7:0] code_lo, input logic [2:0] len);
		code_pair = (first == {4'h0, `TAC_CODE_SLOT}) && (second == code_lo)
			&& (len == `TAC_LEN_LONG);
	endfunction : code_pair

	wire ok = req_end_i && req_check_ok_i; // R18
	wire is_slot = (byte0_ff[3:0] == `TAC_CODE_SLOT); // R01
	wire is_search = code_pair(byte0_ff, byte1_ff, `TAC_CODE_SEARCH_LO, len_ff); // R02
	wire is_round = code_pair(byte0_ff, byte1_ff, `TAC_CODE_ROUND_LO, len_ff); // R06
	// Index 0 is the round-open code and never a probe
	wire is_probe = is_slot && (byte0_ff[7:4] != 4'h0)
		&& (len_ff == `TAC_LEN_SHORT); // R11 R12
	wire is_pick = (byte0_ff == `TAC_CODE_PICK) && (len_ff == `TAC_LEN_LONG); // R16
	wire is_sort = (byte0_ff == `TAC_CODE_SORT) && (len_ff == `TAC_LEN_SHORT); // R17
	// Memory, fetch and retire codes are recognised only to be ignored here
	wire is_other = (byte0_ff == `TAC_CODE_READ) || (byte0_ff == `TAC_CODE_WRITE)
		|| (byte0_ff == `TAC_CODE_FETCH) || (byte0_ff == `TAC_CODE_RETIRE); // R01
	wire in_inv = (state_ff == TAC_INVENTORY);
	wire do_search = ok && is_search && (state_ff == TAC_READY); // R03
	wire do_round = ok && is_round && in_inv; // R07
	wire do_probe = ok && is_probe && in_inv; // R07
	wire do_pick = ok && is_pick && in_inv && (byte1_ff == session_identifier_ff); // R16
	wire do_sort = ok && is_sort && (state_ff == TAC_SELECTED); // R17
	wire [7:0] round_id = {session_identifier_ff[7:4], rand_val[3:0]}; // R08
	wire round_hit = (rand_val[3:0] == 4'h0); // R10
	wire probe_hit = (session_identifier_ff[3:0] == byte0_ff[7:4]); // R13

	////////////////////////////////////////////////////////////////
	// State, identifier and reply
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= TAC_READY;
			session_identifier_ff <= 8'h00;
			reply_valid_ff <= 1'b0;
			reply_byte_ff <= 8'h00;
		end else begin
			reply_valid_ff <= 1'b0;
			case (state_ff)
				TAC_READY: begin
					if (do_search) begin
						state_ff <= TAC_INVENTORY; // R03
						session_identifier_ff <= rand_val; // R03
						reply_valid_ff <= 1'b1; // R04
						reply_byte_ff <= rand_val;
					end
				end
				TAC_INVENTORY: begin
					if (do_round) begin
						session_identifier_ff <= round_id; // R08 R09
						reply_valid_ff <= round_hit; // R10
						reply_byte_ff <= round_id;
					end else if (do_probe) begin
						reply_valid_ff <= probe_hit; // R13
						reply_byte_ff <= session_identifier_ff;
					end else if (do_pick) begin
						state_ff <= TAC_SELECTED; // R16
						reply_valid_ff <= 1'b1;
						reply_byte_ff <= session_identifier_ff;
					end
				end
				TAC_SELECTED: begin
					if (do_sort) begin
						state_ff <= TAC_INVENTORY; // R17
					end
				end
				default: begin
					state_ff <= TAC_READY;
				end
			endcase
		end
	end

	assign reply_valid_o = reply_valid_ff;
	assign reply_byte_o = reply_byte_ff;
	assign tag_state_o = state_ff;

	////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_round_req;
		do_round;
	endsequence
	sequence s_no_effect;
		!reply_valid_o && $stable(state_ff);
	endsequence

	a_search_reply: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R03
		do_search |=> reply_valid_o && tag_state_o == 2'(TAC_INVENTORY)
			&& reply_byte_o == session_identifier_ff)
		else $error("search-begin reply missing");
	a_search_uncond: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R04
		do_search |=> reply_valid_o)
		else $error("search-begin reply gated");
	a_inv_only: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R07
		ok && (is_round || is_probe) && !in_inv |=> !reply_valid_o && $stable(state_ff))
		else $error("slot request acted outside inventory");
	a_round_low: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R08
		s_round_req |=> session_identifier_ff[7:4] == $past(session_identifier_ff[7:4]))
		else $error("round changed identifier high nibble");
	a_slot_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R09
		!do_round && !do_search |=> $stable(session_identifier_ff))
		else $error("slot draw changed without cause");
	a_round_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R10
		s_round_req |=> reply_valid_o == (session_identifier_ff[3:0] == 4'h0))
		else $error("round reply does not follow zero slot");
	a_probe_match: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R13
		do_probe |=> reply_valid_o == (session_identifier_ff[3:0] == $past(byte0_ff[7:4])))
		else $error("probe reply mismatch");
	a_pick_sel: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
		do_pick |=> tag_state_o == 2'(TAC_SELECTED) && reply_valid_o)
		else $error("tag-pick not selected");
	a_sort_back: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
		do_sort |=> tag_state_o == 2'(TAC_INVENTORY) && !reply_valid_o)
		else $error("return-to-sorting failed");
	a_bad_check: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R18
		req_end_i && !req_check_ok_i |=> !reply_valid_o && $stable(state_ff))
		else $error("bad check request acted on");

	// Refused requests leave state and reply untouched, replies last one cycle, round reply carries identifier
	a_overlong: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R18
		ok && len_ff > `TAC_LEN_LONG |=> s_no_effect)
		else $error("overlong request acted on");
	a_zero_index: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R11
		ok && byte0_ff == {4'h0, `TAC_CODE_SLOT} && len_ff == `TAC_LEN_SHORT |=> s_no_effect)
		else $error("probe with index zero acted on");
	a_other_ignored: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R01
		ok && is_other |=> s_no_effect)
		else $error("memory or retire code acted on");
	a_pick_miss: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
		ok && is_pick && byte1_ff != session_identifier_ff |=> s_no_effect)
		else $error("tag-pick with foreign identifier acted on");
	a_sort_other: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R17
		ok && is_sort && state_ff != TAC_SELECTED |=> s_no_effect)
		else $error("return-to-sorting acted outside selected");
	a_search_again: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R03
		ok && is_search && state_ff != TAC_READY |=> s_no_effect)
		else $error("search-begin acted outside ready");
	a_ready_quiet: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
		state_ff == TAC_READY && !do_search |=> !reply_valid_o)
		else $error("reply from ready without search-begin");
	a_reply_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R03
		reply_valid_o |=> !reply_valid_o)
		else $error("reply held longer than one cycle");
	a_round_id: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R08
		s_round_req |=> reply_byte_o == session_identifier_ff)
		else $error("round reply byte differs from identifier");
endmodule : tac_decoder
`default_nettype wire

// ### tac_reader.sv
// Reader model that sends request frames to the tag
`timescale 1ns/1ps
`default_nettype none
module tac_reader (
	// Clock
	input wire logic clk_sys_i,
	// Request frame to the tag
	output logic req_byte_valid_o,
	output logic [7:0] req_byte_o,
	output logic req_end_o,
	output logic req_check_ok_o
);
	initial begin
		req_byte_valid_o = 1'b0;
		req_byte_o = 8'h00;
		req_end_o = 1'b0;
		req_check_ok_o = 1'b0;
	end
	// Code bytes, then check low and high; idle byte line inverts
	task automatic send(input logic [7:0] b0, input logic [7:0] b1, input int n,
		input logic ok, input logic [15:0] crc);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_i);
			req_byte_valid_o = 1'b1;
			req_byte_o = (i == 0) ? b0 : (i == 1 && n >= 4) ? b1 :
				(i == n - 2) ? crc[7:0] : crc[15:8];
		end
		@(negedge clk_sys_i);
		req_byte_valid_o = 1'b0;
		req_byte_o = ~req_byte_o;
		req_end_o = 1'b1;
		req_check_ok_o = ok;
		@(negedge clk_sys_i);
		req_end_o = 1'b0;
		req_check_ok_o = 1'b0;
	endtask : send
endmodule : tac_reader
`default_nettype wire

// ### tb.sv
// Testbench for the tag anticollision command decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_sys_i, rst_i, v, e, ok, rv;
	logic [7:0] b, rb, id;
	logic [1:0] st;
	logic [31:0] lf;
	logic [7:0] rq[$];
	int n_fail, checks_done, hits, s, m_st;
	tac_decoder i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_byte_valid_i(v),
		.req_byte_i(b), .req_end_i(e), .req_check_ok_i(ok), .reply_valid_o(rv),
		.reply_byte_o(rb), .tag_state_o(st));
	tac_reader i_rdr (.clk_sys_i(clk_sys_i), .req_byte_valid_o(v), .req_byte_o(b),
		.req_end_o(e), .req_check_ok_o(ok));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) if (rv === 1'b1) rq.push_back(rb);
	function automatic logic [15:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf[15:0];
	endfunction : rnd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Sends one frame, then steps the state model; -1 marks a random reply count
	task automatic fr(input logic [7:0] b0, input logic [7:0] b1, input int n, input logic k);
		int m_rep;
		rq.delete();
		i_rdr.send(b0, b1, n, k, rnd());
		repeat (2) @(negedge clk_sys_i);
		m_rep = 0;
		if (k && n == 4 && b0 == 8'h06 && b1 == 8'h00 && m_st == 0) begin
			m_st = 1;
			m_rep = 1;
		end else if (k && n == 4 && b0 == 8'h0E && b1 == id && m_st == 1) begin
			m_st = 2;
			m_rep = 1;
		end else if (k && n == 3 && b0 == 8'h0C && m_st == 2) begin
			m_st = 1;
		end else if (k && b0[3:0] == 4'h6 && m_st == 1) begin
			m_rep = -1;
		end
		chk({6'h00, st}, 8'(m_st));
		if (m_rep >= 0) chk(8'(rq.size()), 8'(m_rep));
	endtask : fr
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#800000;
		n_fail++;
		end_of_test();
	end
	initial begin
		n_fail = 0;
		checks_done = 0;
		lf = 32'h00017C2C;
		m_st = 0;
		rst_i = 1'b1;
		repeat (4) @(negedge clk_sys_i);
		rst_i = 1'b0;
		fr(8'h16, 8'h00, 3, 1'b1);
		chk(8'(rq.size()), 8'h00);
		fr(8'h06, 8'h04, 4, 1'b1);
		chk(8'(rq.size()), 8'h00);
		fr(8'h06, 8'h00, 4, 1'b0);
		chk(8'(rq.size()), 8'h00);
		fr(8'h06, 8'h00, 3, 1'b1);
		chk({6'h00, st}, 8'h00);
		fr(8'h06, 8'h00, 5, 1'b1);
		fr(8'h0C, 8'h00, 3, 1'b1);
		fr(8'h06, 8'h00, 4, 1'b1);
		chk(8'(rq.size()), 8'h01);
		chk({6'h00, st}, 8'h01);
		id = rq[0];
		fr(8'h06, 8'h00, 4, 1'b1);
		chk(8'(rq.size()), 8'h00);
		for (int r = 0; r < 3; r++) begin
			fr(8'h06, 8'h04, 4, 1'b1);
			hits = rq.size();
			s = 0;
			if (hits == 1) chk(rq[0], {id[7:4], 4'h0});
			for (int k = 1; k < 16; k++) begin
				fr({k[3:0], 4'h6}, 8'h00, 3, 1'b1);
				if (rq.size() > 0) begin
					hits++;
					s = k;
					chk(rq[0], {id[7:4], k[3:0]});
				end
			end
			chk(8'(hits), 8'h01);
		end
		id = {id[7:4], s[3:0]};
		fr({s[3:0], 4'h6}, 8'h00, 3, 1'b0);
		chk(8'(rq.size()), 8'h00);
		fr(8'h0E, id ^ 8'h80, 4, 1'b1);
		chk(8'(rq.size()), 8'h00);
		fr(8'h0E, id, 4, 1'b1);
		chk(rq[0], id);
		chk({6'h00, st}, 8'h02);
		fr(8'h0F, 8'h00, 3, 1'b1);
		fr({s[3:0], 4'h6}, 8'h00, 3, 1'b1);
		chk(8'(rq.size()), 8'h00);
		fr(8'h0C, 8'h00, 4, 1'b1);
		chk({6'h00, st}, 8'h02);
		fr(8'h0C, 8'h00, 3, 1'b1);
		chk({rq.size() == 0, 5'h00, st}, 8'h81);
		rst_i = 1'b1;
		@(negedge clk_sys_i);
		chk({6'h00, st}, 8'h00);
		m_st = 0;
		rst_i = 1'b0;
		fr(8'h06, 8'h00, 4, 1'b1);
		end_of_test();
	end
endmodule : tb
`default_nettype wire
